// ===== rtl/host_processor_bus_port.sv
// Host processor bus port: pin synchronisers, access sequencer and open-drain interrupt.
// Notes on behaviour
// R01: While select is high every other host input is ignored, and while low the bus is served.
// R02: In direction-line style a low read/not-write means write and a high one means read.
// R03: In strobe style a low write strobe means the host drives data and the port captures it.
// R04: In strobe style a low read strobe makes the port present the addressed word.
// R05: In direction-line style the shared enable/read strobe input is held low by the system.
// R06: The interrupt pin is pulled low while any internal interrupt is pending and released otherwise.
// R07: The twelve-bit address selects one internal location for each access.
// R08: Data moves over a sixteen-bit two-way bus, driven by the host on writes and the port on reads.
// R09: All port logic runs on the single system clock.
// R10: An active-low reset returns the port to its initial state and needs the clock running.
// R11: The data bus is driven only during a selected read and released at all other times.
module host_processor_bus_port (
  // Clock and reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 nrst,
  input  wire logic                                 clk_en,
  // Bus style selection
  input  wire logic                                 bus_style,
  // Host bus pins
  input  wire logic                                 host_cs_n,
  input  wire logic [host_port_pkg::ADDR_WIDTH-1:0] host_addr,
  input  wire logic                                 host_rnw_wr_n,
  input  wire logic                                 host_oe_rd_n,
  input  wire logic [host_port_pkg::DATA_WIDTH-1:0] host_data_in,
  output logic      [host_port_pkg::DATA_WIDTH-1:0] host_data_out,
  output logic                                      host_data_oe,
  // Interrupt pin
  input  wire logic                                 irq_pending,
  output logic                                      host_irq_out,
  output logic                                      host_irq_oe,
  // Internal side
  output logic                                      int_wr_pulse,
  output logic                                      int_rd_pulse,
  output logic      [host_port_pkg::ADDR_WIDTH-1:0] int_addr,
  output logic      [host_port_pkg::DATA_WIDTH-1:0] int_wr_data
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1}; // R10
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Control and data buses each pass two flops; the sequencer acts on the first
  // synchronised sample, with no extra wait for skew between lines to settle.
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned BUS_W  = host_port_pkg::ADDR_WIDTH + host_port_pkg::DATA_WIDTH;

  logic [CTRL_W-1:0] ctrl_meta_reg;
  logic [CTRL_W-1:0] ctrl_sync_reg;
  logic [BUS_W-1:0]  bus_meta_reg;
  logic [BUS_W-1:0]  bus_sync_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_meta_reg <= 3'b111;
      ctrl_sync_reg <= 3'b111;
      bus_meta_reg  <= '0;
      bus_sync_reg  <= '0;
    end else if (clk_en) begin
      ctrl_meta_reg <= {host_cs_n, host_rnw_wr_n, host_oe_rd_n};
      ctrl_sync_reg <= ctrl_meta_reg;
      bus_meta_reg  <= {host_addr, host_data_in};
      bus_sync_reg  <= bus_meta_reg;
    end
  end

  logic                                 cs_n_s;
  logic                                 rnw_s;
  logic                                 rd_n_s;
  logic [host_port_pkg::ADDR_WIDTH-1:0] addr_s;
  logic [host_port_pkg::DATA_WIDTH-1:0] data_s;

  assign cs_n_s = ctrl_sync_reg[2];
  assign rnw_s  = ctrl_sync_reg[1];
  assign rd_n_s = ctrl_sync_reg[0];
  assign addr_s = bus_sync_reg[BUS_W-1:host_port_pkg::DATA_WIDTH];
  assign data_s = bus_sync_reg[host_port_pkg::DATA_WIDTH-1:0];

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic want_wr;
  logic want_rd;

  always_comb begin
    want_wr = 1'b0;
    want_rd = 1'b0;
    if (!cs_n_s) begin // R01
      if (bus_style == host_port_pkg::STYLE_DIRECTION) begin
        // The shared strobe is expected tied low here and is not looked at.
        want_wr = !rnw_s; // R02 R05
        want_rd = rnw_s;  // R02
      end else begin
        want_wr = !rnw_s && rd_n_s;  // R03
        want_rd = !rd_n_s && rnw_s;  // R04
      end
    end
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  host_port_pkg::access_state_type state_reg;
  host_port_pkg::access_state_type state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      host_port_pkg::ST_IDLE: begin
        if (want_wr) begin
          state_next = host_port_pkg::ST_WRITE;
        end else if (want_rd) begin
          state_next = host_port_pkg::ST_READ;
        end
      end
      host_port_pkg::ST_WRITE: begin
        state_next = host_port_pkg::ST_DONE;
      end
      host_port_pkg::ST_READ: begin
        state_next = host_port_pkg::ST_DONE;
      end
      host_port_pkg::ST_DONE: begin
        if (!want_wr && !want_rd) begin
          state_next = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= host_port_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next; // R09
    end
  end

  // Write data is taken while the strobe is still low, on the first sample in which it is seen synchronised.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_addr     <= host_port_pkg::ADDR_RESET;
      int_wr_data  <= host_port_pkg::DATA_RESET;
      int_wr_pulse <= 1'b0;
      int_rd_pulse <= 1'b0;
    end else if (clk_en) begin
      int_wr_pulse <= 1'b0;
      int_rd_pulse <= 1'b0;
      if (state_reg == host_port_pkg::ST_IDLE && want_wr) begin
        int_addr     <= addr_s;    // R07
        int_wr_data  <= data_s;    // R03 R08
        int_wr_pulse <= 1'b1;
      end else if (state_reg == host_port_pkg::ST_IDLE && want_rd) begin
        int_addr     <= addr_s;    // R07
        int_rd_pulse <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [host_port_pkg::DATA_WIDTH-1:0] mem_rd_data;

  host_port_mem u_mem (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .wr_en   (int_wr_pulse),
    .wr_addr (int_addr),
    .wr_data (int_wr_data),
    .rd_en   (int_rd_pulse),
    .rd_addr (int_addr),
    .rd_data (mem_rd_data)
  );

  // ****************************************************************
  // Read data drive
  // ****************************************************************
  logic rd_fetch_reg;
  logic rd_valid_reg;

  // The memory answers one edge after the read pulse, so the pin register waits one edge more.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_fetch_reg <= 1'b0;
    end else if (clk_en) begin
      rd_fetch_reg <= (state_reg == host_port_pkg::ST_READ);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      if (rd_fetch_reg) begin
        rd_valid_reg <= 1'b1;
      end else if (!want_rd) begin
        rd_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_data_out <= host_port_pkg::DATA_RESET;
    end else if (clk_en && rd_fetch_reg) begin
      host_data_out <= mem_rd_data; // R04 R08
    end
  end

  // Enable uses the raw pins so the bus is released as soon as the host ends the read.
  logic raw_read;

  // Both strobes low is no read, matching the decode above.
  assign raw_read = !host_cs_n && host_rnw_wr_n
                  && ((bus_style == host_port_pkg::STYLE_DIRECTION) || !host_oe_rd_n);
  assign host_data_oe = rst_n && rd_valid_reg && raw_read; // R11

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  logic irq_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= irq_pending; // R06
    end
  end

  assign host_irq_out = 1'b0;
  assign host_irq_oe  = irq_reg; // R06

endmodule

// ===== rtl/host_port_pkg.sv
// Package of constants and types shared by the host processor bus port.
package host_port_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_WIDTH = 12;
  localparam int unsigned DATA_WIDTH = 16;
  localparam int unsigned MEM_DEPTH  = 4096;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_MHZ     = 100;
  localparam int unsigned NOMINAL_CLK_MHZ = 50;
  localparam int unsigned SYNC_STAGES     = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 16'h0000;
  localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 12'h000;

  // ****************************************************************
  // Bus styles and access states
  // ****************************************************************
  localparam logic STYLE_DIRECTION = 1'b0;
  localparam logic STYLE_STROBE    = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10,
    ST_DONE  = 2'b11
  } access_state_type;

endpackage

// ===== rtl/host_port_mem.sv
// Word memory behind the host port with a registered read port.
module host_port_mem (
  // Clock
  input  wire logic                                   clk_sys,
  input  wire logic                                   clk_en,
  // Write port
  input  wire logic                                   wr_en,
  input  wire logic [host_port_pkg::ADDR_WIDTH-1:0]   wr_addr,
  input  wire logic [host_port_pkg::DATA_WIDTH-1:0]   wr_data,
  // Read port
  input  wire logic                                   rd_en,
  input  wire logic [host_port_pkg::ADDR_WIDTH-1:0]   rd_addr,
  output logic      [host_port_pkg::DATA_WIDTH-1:0]   rd_data
);

  logic [host_port_pkg::DATA_WIDTH-1:0] mem_array [host_port_pkg::MEM_DEPTH];

  // The array has no reset so it maps to block memory.
  always_ff @(posedge clk_sys) begin
    if (clk_en && wr_en) begin
      mem_array[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && rd_en) begin
      rd_data <= mem_array[rd_addr];
    end
  end

endmodule

// ===== bench/host_port_chk_sva.sv
// Timing checker for the host port, bound to its top module.
module host_port_chk (
  // Clock and reset
  input wire logic                                 clk_sys,
  input wire logic                                 nrst,
  // Host pins
  input wire logic                                 bus_style,
  input wire logic                                 host_cs_n,
  input wire logic [host_port_pkg::ADDR_WIDTH-1:0] host_addr,
  input wire logic                                 host_rnw_wr_n,
  input wire logic                                 host_oe_rd_n,
  input wire logic [host_port_pkg::DATA_WIDTH-1:0] host_data_in,
  input wire logic                                 host_data_oe,
  input wire logic                                 irq_pending,
  input wire logic                                 host_irq_out,
  input wire logic                                 host_irq_oe,
  // Internal side
  input wire logic                                 int_wr_pulse,
  input wire logic                                 int_rd_pulse,
  input wire logic [host_port_pkg::ADDR_WIDTH-1:0] int_addr,
  input wire logic [host_port_pkg::DATA_WIDTH-1:0] int_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Outputs are unknown until the first edge has applied reset, so that edge is skipped.
  logic started_reg = 1'b0;

  always_ff @(posedge clk_sys) begin
    started_reg <= 1'b1;
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  cs_high_quiet_a: assert property (
    $past(host_cs_n, 2) && $past(host_cs_n, 3) && $past(host_cs_n, 4) && $past(host_cs_n, 5)
    |-> !int_wr_pulse && !int_rd_pulse) else $error("access taken while deselected");
  wr_cause_a: assert property (
    int_wr_pulse |-> !$past(host_cs_n, 2) && !$past(host_rnw_wr_n, 2) && (!bus_style || $past(host_oe_rd_n, 2)))
    else $error("write without a write request");
  rd_cause_a: assert property (
    int_rd_pulse |-> !$past(host_cs_n, 2) && $past(host_rnw_wr_n, 2) && (!bus_style || !$past(host_oe_rd_n, 2)))
    else $error("read without a read request");
  wr_single_a: assert property (int_wr_pulse |=> !int_wr_pulse) else $error("write pulse too long");
  wr_word_a: assert property (
    int_wr_pulse |-> int_wr_data == $past(host_data_in) && int_addr == $past(host_addr))
    else $error("write word or address wrong");
  rd_addr_a: assert property (int_rd_pulse |-> int_addr == $past(host_addr)) else $error("read address wrong");
  drive_only_read_a: assert property (
    host_data_oe |-> !host_cs_n && host_rnw_wr_n && (!bus_style || !host_oe_rd_n))
    else $error("data bus driven outside a read");
  irq_follow_a: assert property (
    $past(nrst, 3) |-> host_irq_oe == $past(irq_pending) && !host_irq_out) else $error("interrupt pin wrong");
  reset_quiet_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    !nrst && started_reg |-> !host_data_oe && !host_irq_oe && !int_wr_pulse && !int_rd_pulse)
    else $error("outputs active in reset");
  cover property (int_wr_pulse);
  cover property (int_rd_pulse);
  cover property (host_data_oe && bus_style);
  cover property (host_irq_oe);
endmodule

bind host_processor_bus_port host_port_chk chk (
  .clk_sys(clk_sys), .nrst(nrst), .bus_style(bus_style), .host_cs_n(host_cs_n), .host_addr(host_addr),
  .host_rnw_wr_n(host_rnw_wr_n), .host_oe_rd_n(host_oe_rd_n), .host_data_in(host_data_in),
  .host_data_oe(host_data_oe), .irq_pending(irq_pending), .host_irq_out(host_irq_out),
  .host_irq_oe(host_irq_oe), .int_wr_pulse(int_wr_pulse), .int_rd_pulse(int_rd_pulse),
  .int_addr(int_addr), .int_wr_data(int_wr_data));

// ===== bench/host_bus_master.sv
// Behavioural local processor that drives the host pins.
module host_bus_master (
  // Clock and style
  input wire logic                                 clk_sys,
  input wire logic                                 bus_style,
  // Answer from the port
  input wire logic [host_port_pkg::DATA_WIDTH-1:0] host_data_out,
  input wire logic                                 host_data_oe,
  // Host pins
  output logic                                     host_cs_n,
  output logic [host_port_pkg::ADDR_WIDTH-1:0]     host_addr,
  output logic                                     host_rnw_wr_n,
  output logic                                     host_oe_rd_n,
  output logic [host_port_pkg::DATA_WIDTH-1:0]     host_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_cs_n = 1'b1;
    host_addr = 12'h000;
    host_rnw_wr_n = 1'b1;
    host_oe_rd_n = 1'b0;
    host_data_in = 16'h0000;
  end
  // A ghost access sets every pin for the access but keeps chip select high.
  task automatic access(input logic wr, input logic ghost, input logic [11:0] a, input logic [15:0] d,
                        input int extra, output logic [15:0] q, output logic oe_on, output logic oe_off);
    @(negedge clk_sys);
    host_cs_n = ghost;
    host_addr = a;
    host_data_in = wr ? d : ~host_data_in;
    host_rnw_wr_n = !wr;
    host_oe_rd_n = bus_style ? wr : 1'b0;
    repeat (6 + extra) @(negedge clk_sys);
    q = host_data_out;
    oe_on = host_data_oe;
    host_cs_n = 1'b1;
    host_rnw_wr_n = 1'b1;
    host_oe_rd_n = bus_style;
    // Released data must not keep its last value, so it is inverted.
    host_data_in = ~host_data_in;
    #1 oe_off = host_data_oe;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule

// ===== bench/host_processor_bus_port_tb_top.sv
// Self-checking testbench for the host processor bus port.
module host_processor_bus_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, nrst, bus_style, irq_pending, host_cs_n, host_rnw_wr_n, host_oe_rd_n;
  logic        host_data_oe, host_irq_out, host_irq_oe, on, off;
  logic [11:0] host_addr;
  logic [15:0] host_data_in, host_data_out, q;
  logic [11:0] a_q [6];
  logic [15:0] d_q [6];
  int          num_errors, compares, cycles;

  host_processor_bus_port uut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .bus_style(bus_style),
    .host_cs_n(host_cs_n), .host_addr(host_addr), .host_rnw_wr_n(host_rnw_wr_n), .host_oe_rd_n(host_oe_rd_n),
    .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .irq_pending(irq_pending), .host_irq_out(host_irq_out), .host_irq_oe(host_irq_oe),
    .int_wr_pulse(), .int_rd_pulse(), .int_addr(), .int_wr_data());
  host_bus_master bm (.clk_sys(clk_sys), .bus_style(bus_style), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_cs_n(host_cs_n), .host_addr(host_addr),
    .host_rnw_wr_n(host_rnw_wr_n), .host_oe_rd_n(host_oe_rd_n), .host_data_in(host_data_in));

  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    check_word(name, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Corner words and both ends of the address range sit among the random ones.
  function automatic logic [15:0] pick_data(int i);
    return (i == 0) ? 16'h0000 : (i == 5) ? 16'hffff : 16'($urandom);
  endfunction
  function automatic logic [11:0] pick_addr(int i);
    return {4'(i * 3), (i == 0) ? 8'h00 : (i == 5) ? 8'hff : 8'($urandom)};
  endfunction

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    nrst = 1'b0;
    bus_style = 1'b0;
    irq_pending = 1'b0;
    void'($urandom(32'h6ba9));
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (int s = 0; s < 2; s++) begin
      bus_style = s[0];
      for (int i = 0; i < 6; i++) begin
        a_q[i] = pick_addr(i);
        d_q[i] = pick_data(i);
        bm.access(1'b1, 1'b0, a_q[i], d_q[i], $urandom_range(3), q, on, off);
        check_bit("write oe", 1'b0, on);
      end
      bm.access(1'b1, 1'b1, a_q[0], ~d_q[0], 0, q, on, off);
      for (int i = 0; i < 6; i++) begin
        bm.access(1'b0, 1'b0, a_q[i], 16'h0000, $urandom_range(3), q, on, off);
        check_word("read data", d_q[i], q);
        check_bit("read oe", 1'b1, on);
        check_bit("oe release", 1'b0, off);
      end
      $display("test style %0d done", s);
    end
    irq_pending = 1'b1;
    repeat (2) @(negedge clk_sys);
    check_bit("irq oe", 1'b1, host_irq_oe);
    check_bit("irq out", 1'b0, host_irq_out);
    nrst = 1'b0;
    #1 check_bit("reset irq oe", 1'b0, host_irq_oe);
    irq_pending = 1'b0;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (5) @(negedge clk_sys);
    check_bit("irq idle", 1'b0, host_irq_oe);
    $display("test interrupt and reset done");
    close_out();
  end
endmodule
